// >>> rcs_supervisor.sv
// Reset and clock supervisor: merges reset sources, reloads regulator
// defaults, selects the core clock and exposes control over a register port.
// Assumes one 40 MHz clock; pins arrive asynchronously, USB and watchdog
// signals come from logic on the same clock.
// What this block does
// - Core supply below monitor threshold asserts internal reset.
// - Button held longer than about 5.6 s forces a reset.
// - Software bit disables the long-press reset entirely.
// - Watchdog expiry or low external reset pin also resets.
// - Reset keeps regulators on and reloads default voltage settings.
// - Regulators turn off only by software shutdown bits.
// - Software can read the current power button level.
// - Core clock factor selectable from 1.0 to 8.0 in 0.5 steps.
// - With USB connected the factor is forced to 5.0 (60 MHz).
// - External reset low disables clock buffer, powers down digital section.
// - USB suspend selects RTC clock and powers down main oscillator.
// - General-purpose I/O undriven at power-up and during reset.
`timescale 1ns/1ps
module rcs_supervisor #(
   parameter int TICK_CYC = rcs_pkg::TICK_CYC,
   parameter int PRESS_TICKS = rcs_pkg::PRESS_TICKS
) (
   input wire logic clk_i,                                   // Core clock
   input wire logic sys_rst_i,                               // Power-on reset
   input wire logic [rcs_pkg::ADDR_W-1:0] reg_addr_i,        // Register address
   input wire logic [rcs_pkg::DATA_W-1:0] reg_wdata_i,       // Write data
   input wire logic reg_wr_i,                                // Write strobe
   input wire logic reg_rd_i,                                // Read strobe
   output logic [rcs_pkg::DATA_W-1:0] reg_rdata_o,           // Read data
   input wire logic power_button_in_i,                       // Button pin
   input wire logic external_reset_n_i,                      // Reset pin, low
   input wire logic core_below_threshold_i,                  // Supply monitor
   input wire logic watchdog_expire_i,                       // Watchdog fired
   input wire logic usb_connected_i,                         // USB attached
   input wire logic usb_suspend_i,                           // USB suspended
   output logic chip_reset_o,                                // Internal reset
   output logic clock_buffer_en_o,                           // Clock buffer on
   output logic digital_pwrdn_o,                             // Digital powerdown
   output logic [3:0] pll_factor_o,                          // PLL factor code
   output logic core_clk_rtc_o,                              // Core on RTC clock
   output logic main_osc_pd_o,                               // Main osc off
   output logic [rcs_pkg::VOLT_W-1:0] reg_volt_o,            // Regulator levels
   output logic [rcs_pkg::NREG-1:0] reg_shutdown_o,          // Regulator off
   output logic [rcs_pkg::GPIO_W-1:0] gpio_oe_o              // GPIO drive enables
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   logic [2:0] pins_s;
   logic btn_s, ext_n_s, core_low_s;
   logic any_src;
   rcs_press_if pif ();

   // Pin levels pass two flops before any logic sees them
   rcs_sync #(.W(3), .RST_VAL(rcs_pkg::SYNC_RST)) u_sync (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({core_below_threshold_i, external_reset_n_i, power_button_in_i}),
      .sync_o(pins_s)
   );
   assign btn_s = pins_s[0];
   assign ext_n_s = pins_s[1];
   assign core_low_s = pins_s[2];

   rcs_press_timer #(.TICK_CYC(TICK_CYC), .PRESS_TICKS(PRESS_TICKS)) u_press (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pif(pif)
   );

   // Reset merging
   logic rst_ff, nxt_rst;
   logic [rcs_pkg::NCAUSE-1:0] cause_set;

   always_comb begin
      cause_set = '0;
      cause_set[rcs_pkg::B_C_CORE] = core_low_s;
      cause_set[rcs_pkg::B_C_PRESS] = pif.expired;
      cause_set[rcs_pkg::B_C_WDOG] = watchdog_expire_i;
      cause_set[rcs_pkg::B_C_EXT] = !ext_n_s;
      any_src = |cause_set;
      nxt_rst = any_src;
   end

   // Held high from power-on until every source has gone quiet
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rst_ff <= 1'b1;
      end else begin
         rst_ff <= nxt_rst;
      end
   end

   // Register port and software state
   logic wr_ctrl, wr_pll, wr_volt, wr_cause, wr_gpio;
   logic lp_dis_ff, nxt_lp_dis;
   logic [3:0] pll_ff, nxt_pll;
   logic [rcs_pkg::VOLT_W-1:0] volt_ff, nxt_volt;
   logic [rcs_pkg::NREG-1:0] shdn_ff, nxt_shdn;
   logic [rcs_pkg::NCAUSE-1:0] cause_ff, nxt_cause;
   logic [rcs_pkg::GPIO_W-1:0] oe_ff, nxt_oe;
   logic [rcs_pkg::DATA_W-1:0] rdata_ff, nxt_rdata, rd_mux;

   assign pif.pressed = btn_s;
   assign pif.enable = !lp_dis_ff;

   always_comb begin
      wr_ctrl = 1'b0;
      wr_pll = 1'b0;
      wr_volt = 1'b0;
      wr_cause = 1'b0;
      wr_gpio = 1'b0;
      if (reg_wr_i && reg_addr_i == rcs_pkg::A_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr_i && reg_addr_i == rcs_pkg::A_PLL) begin
         wr_pll = 1'b1;
      end else if (reg_wr_i && reg_addr_i == rcs_pkg::A_VOLT) begin
         wr_volt = 1'b1;
      end else if (reg_wr_i && reg_addr_i == rcs_pkg::A_CAUSE) begin
         wr_cause = 1'b1;
      end else if (reg_wr_i && reg_addr_i == rcs_pkg::A_GPIO_OE) begin
         wr_gpio = 1'b1;
      end
   end

   // Chip reset reloads software settings; shutdown and cause survive it
   always_comb begin
      nxt_lp_dis = lp_dis_ff;
      nxt_pll = pll_ff;
      nxt_volt = volt_ff;
      nxt_oe = oe_ff;
      nxt_shdn = shdn_ff;
      if (rst_ff) begin
         nxt_lp_dis = 1'b0;
         nxt_pll = rcs_pkg::PLL_RST_CODE;
         nxt_volt = rcs_pkg::VOLT_DEFAULT;
         nxt_oe = '0;
      end else begin
         if (wr_ctrl) begin
            nxt_lp_dis = reg_wdata_i[rcs_pkg::B_LP_DIS];
         end
         // Codes past 8.0x are not a legal factor, so the write is dropped
         if (wr_pll && reg_wdata_i[3:0] <= rcs_pkg::PLL_MAX_CODE) begin
            nxt_pll = reg_wdata_i[3:0];
         end
         if (wr_volt) begin
            nxt_volt = reg_wdata_i[rcs_pkg::VOLT_W-1:0];
         end
         if (wr_gpio) begin
            nxt_oe = reg_wdata_i[rcs_pkg::GPIO_W-1:0];
         end
      end
      // Only a software write turns a regulator off; ones set, zeros ignored
      if (wr_ctrl) begin
         nxt_shdn = shdn_ff | reg_wdata_i[rcs_pkg::B_SHDN_LO +: rcs_pkg::NREG];
      end
      // Write one to clear; a new event in the same cycle wins
      nxt_cause = (cause_ff & ~(wr_cause ? reg_wdata_i[rcs_pkg::NCAUSE-1:0] : '0))
                  | cause_set;
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_mux = '0;
      if (reg_addr_i == rcs_pkg::A_CTRL) begin
         rd_mux[rcs_pkg::B_LP_DIS] = lp_dis_ff;
         rd_mux[rcs_pkg::B_SHDN_LO +: rcs_pkg::NREG] = shdn_ff;
      end else if (reg_addr_i == rcs_pkg::A_PLL) begin
         rd_mux[3:0] = pll_ff;
      end else if (reg_addr_i == rcs_pkg::A_VOLT) begin
         rd_mux[rcs_pkg::VOLT_W-1:0] = volt_ff;
      end else if (reg_addr_i == rcs_pkg::A_STATUS) begin
         rd_mux[rcs_pkg::B_BTN] = btn_s;
         rd_mux[rcs_pkg::B_RST] = rst_ff;
         rd_mux[rcs_pkg::B_USB] = usb_connected_i;
         rd_mux[rcs_pkg::B_SUSP] = usb_suspend_i;
      end else if (reg_addr_i == rcs_pkg::A_CAUSE) begin
         rd_mux[rcs_pkg::NCAUSE-1:0] = cause_ff;
      end else if (reg_addr_i == rcs_pkg::A_GPIO_OE) begin
         rd_mux[rcs_pkg::GPIO_W-1:0] = oe_ff;
      end
      nxt_rdata = reg_rd_i ? rd_mux : '0;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lp_dis_ff <= 1'b0;
         pll_ff <= rcs_pkg::PLL_RST_CODE;
         volt_ff <= rcs_pkg::VOLT_DEFAULT;
         shdn_ff <= '0;
         cause_ff <= '0;
         oe_ff <= '0;
         rdata_ff <= '0;
      end else begin
         lp_dis_ff <= nxt_lp_dis;
         pll_ff <= nxt_pll;
         volt_ff <= nxt_volt;
         shdn_ff <= nxt_shdn;
         cause_ff <= nxt_cause;
         oe_ff <= nxt_oe;
         rdata_ff <= nxt_rdata;
      end
   end

   // Clock control outputs
   logic clkbuf_ff, nxt_clkbuf;
   logic pwrdn_ff, nxt_pwrdn;
   logic [3:0] fac_ff, nxt_fac;
   logic rtc_ff, nxt_rtc;

   always_comb begin
      nxt_clkbuf = ext_n_s;
      nxt_pwrdn = !ext_n_s;
      nxt_fac = usb_connected_i ? rcs_pkg::PLL_USB_CODE : pll_ff;
      nxt_rtc = usb_suspend_i;
   end

   // Suspend drives both clock select and oscillator power-down together
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         clkbuf_ff <= 1'b0;
         pwrdn_ff <= 1'b1;
         fac_ff <= rcs_pkg::PLL_RST_CODE;
         rtc_ff <= 1'b0;
      end else begin
         clkbuf_ff <= nxt_clkbuf;
         pwrdn_ff <= nxt_pwrdn;
         fac_ff <= nxt_fac;
         rtc_ff <= nxt_rtc;
      end
   end

   assign chip_reset_o = rst_ff;
   assign reg_rdata_o = rdata_ff;
   assign clock_buffer_en_o = clkbuf_ff;
   assign digital_pwrdn_o = pwrdn_ff;
   assign pll_factor_o = fac_ff;
   assign core_clk_rtc_o = rtc_ff;
   assign main_osc_pd_o = rtc_ff;
   assign reg_volt_o = volt_ff;
   assign reg_shutdown_o = shdn_ff;
   assign gpio_oe_o = oe_ff;

   a_core_low_reset: assert property (core_low_s |=> chip_reset_o)
      else $error("core supply low did not reset");
   a_press_reset: assert property (pif.expired |=> chip_reset_o)
      else $error("long press did not reset");
   a_wdog_ext_reset: assert property ((watchdog_expire_i || !ext_n_s) |=> chip_reset_o)
      else $error("watchdog or pin did not reset");
   a_volt_reload: assert property (chip_reset_o |=> reg_volt_o == rcs_pkg::VOLT_DEFAULT)
      else $error("regulator defaults not reloaded");
   a_shutdown_sw_only: assert property (!$stable(reg_shutdown_o) |->
      $past(reg_wr_i) && $past(reg_addr_i) == rcs_pkg::A_CTRL
      && ($past(reg_shutdown_o) & ~reg_shutdown_o) == '0)
      else $error("regulator shutdown without software write");
   a_button_read: assert property ((reg_rd_i && reg_addr_i == rcs_pkg::A_STATUS) |=>
      reg_rdata_o[rcs_pkg::B_BTN] == $past(btn_s))
      else $error("button level not readable");
   a_pll_range: assert property (!usb_connected_i |=> pll_factor_o == $past(pll_ff)
      && pll_factor_o <= rcs_pkg::PLL_MAX_CODE)
      else $error("PLL factor out of range or not from setting");
   a_usb_factor: assert property (usb_connected_i |=> pll_factor_o == rcs_pkg::PLL_USB_CODE)
      else $error("USB factor not forced to 5.0");
   a_ext_clock_off: assert property (!ext_n_s |=> !clock_buffer_en_o && digital_pwrdn_o)
      else $error("clock buffer left on under pin reset");
   a_suspend_rtc: assert property (usb_suspend_i |=> core_clk_rtc_o && main_osc_pd_o)
      else $error("suspend did not switch to RTC clock");
   a_gpio_undriven: assert property (chip_reset_o |=> gpio_oe_o == '0)
      else $error("GPIO driven during reset");
   // A one-cycle watchdog pulse gives a one-cycle reset, so only the last cycle matters
   a_release_sync: assert property ($fell(chip_reset_o) |-> $past(!any_src))
      else $error("reset released with a source active");
   a_release_quiet: assert property (!any_src |=> !chip_reset_o)
      else $error("reset held with every source quiet");
   // Set must beat a same-cycle clear, or a cause could be lost unseen
   a_cause_set_wins: assert property ((cause_set != '0) |=>
      (cause_ff & $past(cause_set)) == $past(cause_set))
      else $error("reset cause lost on clear");
   // Read data stands one cycle only, so a stale word cannot be taken twice
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
      else $error("read data without a read strobe");
   a_resume_main: assert property (!usb_suspend_i |=> !core_clk_rtc_o && !main_osc_pd_o)
      else $error("main clock not restored after suspend");

   c_press_reset: cover property (pif.expired ##1 chip_reset_o);
   c_usb_suspend: cover property (usb_connected_i ##1 usb_suspend_i ##1 core_clk_rtc_o);
   c_shutdown: cover property ($rose(reg_shutdown_o[0]));
   c_cause_clear: cover property (wr_cause && |cause_set);
   c_ext_pin: cover property (!ext_n_s ##1 !clock_buffer_en_o);
endmodule : rcs_supervisor

// >>> rcs_pkg.sv
// Constants shared by the reset and clock supervisor: register map, field
// positions, reset values and timing figures.
// Assumes a single 40 MHz core clock and a 16-bit register port.
package rcs_pkg;
   localparam int CLK_HZ = 40_000_000;           // Core clock rate
   localparam int TICK_MS = 1;                   // Button timer resolution, ms
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int LONG_PRESS_MS = 5600;          // 5.6 s long press
   localparam int PRESS_TICKS = LONG_PRESS_MS / TICK_MS;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int GPIO_W = 16;
   localparam int VOLT_W = 15;                   // Three 5-bit regulator fields
   localparam int NREG = 3;

   // Register map
   localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] A_PLL = 4'h1;
   localparam logic [ADDR_W-1:0] A_VOLT = 4'h2;
   localparam logic [ADDR_W-1:0] A_STATUS = 4'h3;
   localparam logic [ADDR_W-1:0] A_CAUSE = 4'h4;
   localparam logic [ADDR_W-1:0] A_GPIO_OE = 4'h5;

   // CTRL fields: bit 0 long-press disable, bits 3:1 regulator shutdown
   localparam int B_LP_DIS = 0;
   localparam int B_SHDN_LO = 1;
   // STATUS fields
   localparam int B_BTN = 0;
   localparam int B_RST = 1;
   localparam int B_USB = 2;
   localparam int B_SUSP = 3;
   // CAUSE fields
   localparam int B_C_CORE = 0;
   localparam int B_C_PRESS = 1;
   localparam int B_C_WDOG = 2;
   localparam int B_C_EXT = 3;
   localparam int NCAUSE = 4;

   // PLL factor code: factor = (code + 2) / 2, so 0 is 1.0x and 14 is 8.0x
   localparam logic [3:0] PLL_RST_CODE = 4'h0;
   localparam logic [3:0] PLL_MAX_CODE = 4'he;
   localparam logic [3:0] PLL_USB_CODE = 4'h8;   // 5.0x of 12 MHz = 60 MHz

   localparam logic [VOLT_W-1:0] VOLT_DEFAULT = 15'h4210;
   localparam logic [2:0] SYNC_RST = 3'h2;       // {core_low, ext_n, button}
endpackage : rcs_pkg

// >>> rcs_press_if.sv
// Link between the supervisor and its long-press timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface rcs_press_if;
   logic pressed;   // Synchronised button level
   logic enable;    // Long-press reset allowed
   logic expired;   // Held past the long-press time
   modport ctrl (output pressed, output enable, input expired);
   modport timer (input pressed, input enable, output expired);
endinterface : rcs_press_if

// >>> rcs_sync.sv
// Two-flop synchroniser for pin levels entering the core clock domain.
// Assumes inputs are slow levels; a pulse shorter than one cycle can be missed.
`timescale 1ns/1ps
module rcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,            // Core clock
   input wire logic sys_rst_i,        // Synchronous reset, high
   input wire logic [W-1:0] async_i,  // Levels from pins
   output logic [W-1:0] sync_o        // Synchronised levels
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;
endmodule : rcs_sync

// >>> rcs_press_timer.sv
// Long-press timer: a millisecond tick divider and a held-time counter.
// Assumes the button level is already synchronised to clk_i.
`timescale 1ns/1ps
module rcs_press_timer #(
   parameter int TICK_CYC = rcs_pkg::TICK_CYC,
   parameter int PRESS_TICKS = rcs_pkg::PRESS_TICKS
) (
   input wire logic clk_i,        // Core clock
   input wire logic sys_rst_i,    // Synchronous reset, high
   rcs_press_if.timer pif         // Button level, enable, expiry
);
   localparam int TW = $clog2(TICK_CYC + 1);
   localparam int PW = $clog2(PRESS_TICKS + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
   localparam logic [PW-1:0] HELD_FULL = PW'(PRESS_TICKS);

   logic [TW-1:0] div_ff, nxt_div;
   logic [PW-1:0] held_ff, nxt_held;
   logic fire_ff, nxt_fire;
   logic tick;

   // Divider restarts at every press so the held time is measured from it
   always_comb begin
      tick = (div_ff == TICK_LAST);
      nxt_div = (tick || !pif.pressed) ? '0 : div_ff + TW'(1);
      nxt_held = held_ff;
      if (!pif.pressed || !pif.enable) begin
         nxt_held = '0;
      end else if (tick && held_ff != HELD_FULL) begin
         nxt_held = held_ff + PW'(1);
      end
      nxt_fire = pif.pressed && pif.enable && (held_ff == HELD_FULL);
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         div_ff <= '0;
         held_ff <= '0;
         fire_ff <= 1'b0;
      end else begin
         div_ff <= nxt_div;
         held_ff <= nxt_held;
         fire_ff <= nxt_fire;
      end
   end

   assign pif.expired = fire_ff;

   // Expiry only after a full held count with the feature enabled
   a_press_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fire_ff |-> $past(pif.enable) && $past(held_ff) == HELD_FULL)
      else $error("long press fired while disabled or early");
   a_press_fires: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (pif.pressed && pif.enable && held_ff == HELD_FULL) |=> fire_ff)
      else $error("long press did not fire after full count");
endmodule : rcs_press_timer

// >>> rcs_pin_model.sv
// Board parts at the supervisor's pins: the power button and the reset line.
// Assumes the bench commands the levels; both pins are driven levels.
`timescale 1ns/1ps
module rcs_pin_model (
   input wire logic press_i,          // Hold the button down
   input wire logic hold_reset_i,     // Pull the reset line low
   output logic power_button_in_o,    // Button pin, high when pressed
   output logic external_reset_n_o    // Reset pin, low in reset
);
   // Switch to the start-up rail; the reset line is driven high unless held low
   assign power_button_in_o = press_i;
   assign external_reset_n_o = ~hold_reset_i;
endmodule : rcs_pin_model

// >>> reset_and_clock_supervisor_tb_top.sv
// Self-checking bench for the reset and clock supervisor.
// Assumes a short long-press count so the press scenarios stay brief.
`timescale 1ns/1ps
module reset_and_clock_supervisor_tb_top;
   localparam int TICKS = 4;
   localparam int PRESSES = 5;
   localparam int PRESS_WAIT = TICKS * PRESSES + 12;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [rcs_pkg::ADDR_W-1:0] addr = '0;
   logic [rcs_pkg::DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic press = 1'b0;
   logic hold_rst = 1'b0;
   logic core_low = 1'b0;
   logic wdog = 1'b0;
   logic usb_on = 1'b0;
   logic usb_susp = 1'b0;
   logic btn_pin;
   logic rst_pin_n;
   logic [rcs_pkg::DATA_W-1:0] rdata;
   logic chip_rst;
   logic clk_buf;
   logic dig_pd;
   logic [3:0] pll;
   logic on_rtc;
   logic osc_pd;
   logic [rcs_pkg::VOLT_W-1:0] volt;
   logic [rcs_pkg::NREG-1:0] shdn;
   logic [rcs_pkg::GPIO_W-1:0] oe;
   logic [15:0] d;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   rcs_pin_model pins (.press_i(press), .hold_reset_i(hold_rst),
      .power_button_in_o(btn_pin), .external_reset_n_o(rst_pin_n));

   rcs_supervisor #(.TICK_CYC(TICKS), .PRESS_TICKS(PRESSES)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .power_button_in_i(btn_pin),
      .external_reset_n_i(rst_pin_n), .core_below_threshold_i(core_low),
      .watchdog_expire_i(wdog), .usb_connected_i(usb_on), .usb_suspend_i(usb_susp),
      .chip_reset_o(chip_rst), .clock_buffer_en_o(clk_buf), .digital_pwrdn_o(dig_pd),
      .pll_factor_o(pll), .core_clk_rtc_o(on_rtc), .main_osc_pd_o(osc_pd),
      .reg_volt_o(volt), .reg_shutdown_o(shdn), .gpio_oe_o(oe));

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic give_verdict;
      $display("Counts: %0d comparisons, %0d mismatches", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // Cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Wait n edges, then look where outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask : tick

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(negedge clk_i);
      v = rdata;
   endtask : rd_reg

   task automatic t_defaults;
      tick(4);
      chk("chip_reset", 16'h0000, 16'(chip_rst));
      chk("clock_buffer", 16'h0001, 16'(clk_buf));
      chk("volt", 16'h4210, 16'(volt));
      chk("gpio_oe", 16'h0000, oe);
      chk("pll", 16'h0000, 16'(pll));
      rd_reg(rcs_pkg::A_VOLT, d);
      chk("volt read", 16'h4210, d);
      rd_reg(4'hf, d);
      chk("unmapped read", 16'h0000, d);
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_ext_pin;
      wr_reg(rcs_pkg::A_VOLT, 16'h1234);
      wr_reg(rcs_pkg::A_GPIO_OE, 16'hffff);
      tick(1);
      chk("volt written", 16'h1234, 16'(volt));
      chk("gpio_oe written", 16'hffff, oe);
      @(posedge clk_i);
      hold_rst <= 1'b1;
      tick(4);
      chk("chip_reset ext", 16'h0001, 16'(chip_rst));
      chk("clock_buffer off", 16'h0000, 16'(clk_buf));
      chk("digital_pwrdn", 16'h0001, 16'(dig_pd));
      chk("volt reloaded", 16'h4210, 16'(volt));
      chk("gpio_oe in reset", 16'h0000, oe);
      chk("no power off", 16'h0000, 16'(shdn));
      @(posedge clk_i);
      hold_rst <= 1'b0;
      tick(4);
      chk("chip_reset released", 16'h0000, 16'(chip_rst));
      chk("clock_buffer on", 16'h0001, 16'(clk_buf));
      chk("digital_pwrdn off", 16'h0000, 16'(dig_pd));
      $display("test external pin done");
   endtask : t_ext_pin

   task automatic t_sources;
      @(posedge clk_i);
      core_low <= 1'b1;
      tick(4);
      chk("chip_reset core", 16'h0001, 16'(chip_rst));
      @(posedge clk_i);
      core_low <= 1'b0;
      tick(4);
      chk("chip_reset core off", 16'h0000, 16'(chip_rst));
      wr_reg(rcs_pkg::A_CAUSE, 16'h000f);
      @(posedge clk_i);
      wdog <= 1'b1;
      @(posedge clk_i);
      wdog <= 1'b0;
      @(negedge clk_i);
      chk("chip_reset wdog", 16'h0001, 16'(chip_rst));
      tick(2);
      chk("chip_reset wdog off", 16'h0000, 16'(chip_rst));
      rd_reg(rcs_pkg::A_CAUSE, d);
      chk("cause wdog", 16'h0004, d);
      $display("test sources done");
   endtask : t_sources

   task automatic t_press;
      wr_reg(rcs_pkg::A_CTRL, 16'h0001);
      @(posedge clk_i);
      press <= 1'b1;
      tick(PRESS_WAIT);
      chk("press disabled", 16'h0000, 16'(chip_rst));
      rd_reg(rcs_pkg::A_STATUS, d);
      chk("button level", 16'h0001, d);
      @(posedge clk_i);
      press <= 1'b0;
      tick(4);
      rd_reg(rcs_pkg::A_STATUS, d);
      chk("button released", 16'h0000, d);
      wr_reg(rcs_pkg::A_CTRL, 16'h0000);
      @(posedge clk_i);
      press <= 1'b1;
      // Two sync flops, the held count, the expiry flop, then the reset flop
      tick(TICKS * PRESSES + 3);
      chk("press early", 16'h0000, 16'(chip_rst));
      tick(1);
      chk("press reset", 16'h0001, 16'(chip_rst));
      tick(8);
      chk("press reset held", 16'h0001, 16'(chip_rst));
      @(posedge clk_i);
      press <= 1'b0;
      tick(6);
      chk("press released", 16'h0000, 16'(chip_rst));
      $display("test long press done");
   endtask : t_press

   task automatic t_clock;
      for (int c = 0; c <= 14; c++) begin
         wr_reg(rcs_pkg::A_PLL, 16'(c));
         tick(1);
         chk("pll code", 16'(c), 16'(pll));
      end
      wr_reg(rcs_pkg::A_PLL, 16'h000f);
      tick(1);
      chk("pll out of range", 16'h000e, 16'(pll));
      @(posedge clk_i);
      usb_on <= 1'b1;
      tick(2);
      chk("pll usb", 16'h0008, 16'(pll));
      @(posedge clk_i);
      usb_susp <= 1'b1;
      tick(2);
      chk("core on rtc", 16'h0001, 16'(on_rtc));
      chk("osc powered down", 16'h0001, 16'(osc_pd));
      @(posedge clk_i);
      usb_on <= 1'b0;
      usb_susp <= 1'b0;
      tick(2);
      chk("pll restored", 16'h000e, 16'(pll));
      chk("core off rtc", 16'h0000, 16'(on_rtc));
      chk("osc powered up", 16'h0000, 16'(osc_pd));
      $display("test clock done");
   endtask : t_clock

   // Shutdown is sticky, so this scenario runs last
   task automatic t_shutdown;
      wr_reg(rcs_pkg::A_CTRL, 16'h000e);
      tick(1);
      chk("shutdown set", 16'h0007, 16'(shdn));
      @(posedge clk_i);
      hold_rst <= 1'b1;
      tick(4);
      chk("shutdown through reset", 16'h0007, 16'(shdn));
      @(posedge clk_i);
      hold_rst <= 1'b0;
      tick(4);
      chk("chip_reset after shutdown", 16'h0000, 16'(chip_rst));
      chk("shutdown after reset", 16'h0007, 16'(shdn));
      $display("test shutdown done");
   endtask : t_shutdown

   // Main sequence
   initial begin
      repeat (15) @(posedge clk_i);
      @(negedge clk_i);
      chk("gpio_oe power-up", 16'h0000, oe);
      @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_defaults();
      t_ext_pin();
      t_sources();
      t_press();
      t_clock();
      t_shutdown();
      give_verdict();
   end
endmodule : reset_and_clock_supervisor_tb_top
